/* design/ldv_pkg.sv */
// constants, register map and divide-code table for the lock-detect,
// vco calibration and channel divider control block.
// assumes one 10 MHz system clock that is the reference, and an axi4-lite host.
package ldv_pkg;
	localparam int unsigned AXI_AW = 8;
	localparam logic [7:0] ADDR_CTRL0 = 8'h00;
	localparam logic [7:0] ADDR_LD_DELAY = 8'h04;
	localparam logic [7:0] ADDR_VCO_START = 8'h08;
	localparam logic [7:0] ADDR_VCO_FORCE = 8'h0C;
	localparam logic [7:0] ADDR_OUTPUT_DIVIDE_CODE = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_CAL_RESULT = 8'h18;
	localparam logic [7:0] ADDR_DIV_INFO = 8'h1C;
	localparam logic [7:0] ADDR_RB_SEL = 8'h20;
	// first control register fields
	localparam int unsigned CTRL_FCAL_BIT = 0;
	localparam int unsigned CTRL_REUSE_BIT = 1;
	localparam int unsigned CTRL_MUXSEL_BIT = 2;
	localparam int unsigned CTRL_LDTYPE_BIT = 3;
	localparam int unsigned CTRL_MUTE_BIT = 4;
	localparam int unsigned CTRL_CALDIV_LSB = 5;
	// start and force register fields (same layout for values)
	localparam int unsigned CORE_LSB = 0;
	localparam int unsigned AMP_LSB = 4;
	localparam int unsigned BAND_LSB = 16;
	localparam int unsigned FORCE_CORE_BIT = 24;
	localparam int unsigned FORCE_AMP_BIT = 25;
	localparam int unsigned FORCE_BAND_BIT = 26;
	// channel divider register fields
	localparam int unsigned DIV_CODE_LSB = 0;
	localparam int unsigned DIV_PD_BIT = 8;
	localparam int unsigned OUTA_SEL_LSB = 9;
	localparam int unsigned OUTB_SEL_LSB = 11;
	// reset values
	localparam logic [31:0] CTRL0_RST = 32'h0000_0000;
	localparam logic [15:0] LD_DELAY_RST = 16'h0000;
	localparam logic [31:0] VCO_START_RST = 32'h00B7_12C7;
	localparam logic [31:0] VCO_FORCE_RST = 32'h0000_0000;
	localparam logic [31:0] OUTPUT_DIVIDE_CODE_RST = 32'h0000_0B00;
	// encodings
	localparam logic MUX_SEL_READBACK = 1'h0;
	localparam logic MUX_SEL_LOCK = 1'h1;
	localparam logic LOCK_DETECT_TYPE_CAL = 1'h0;
	localparam logic LOCK_DETECT_TYPE_VTUNE = 1'h1;
	localparam logic [1:0] LOCK_STATE_LOCKED = 2'h2;
	localparam logic [1:0] LOCK_STATE_UNLOCKED = 2'h0;
	localparam logic [1:0] SRC_OUTPUT_DIVIDE_CODE = 2'h0;
	localparam logic [1:0] SRC_SYSREF = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [4:0] DIV_CODE_MAX = 5'h11;
	localparam logic [1:0] STAGE_A_RATIO = 2'h2;
	localparam logic [7:0] AMP_CAL_TICKS = 8'h10;
	localparam logic [7:0] BAND_TOP = 8'hFF;
	typedef enum logic [1:0] {CAL_IDLE, CAL_AMP, CAL_FREQ, CAL_DELAY} ldv_cal_state_t;
	// stage b[10:9], c[8:5], d[4:0] for a divide code; zero when invalid
	function automatic logic [10:0] ldv_stages(input logic [4:0] code);
		case (code)
			5'h00: ldv_stages = {2'h1, 4'h1, 5'h01};
			5'h01: ldv_stages = {2'h2, 4'h1, 5'h01};
			5'h02: ldv_stages = {2'h3, 4'h1, 5'h01};
			5'h03: ldv_stages = {2'h2, 4'h2, 5'h01};
			5'h04: ldv_stages = {2'h3, 4'h2, 5'h01};
			5'h05: ldv_stages = {2'h2, 4'h4, 5'h01};
			5'h06: ldv_stages = {2'h2, 4'h6, 5'h01};
			5'h07: ldv_stages = {2'h2, 4'h8, 5'h01};
			5'h08: ldv_stages = {2'h3, 4'h8, 5'h01};
			5'h09: ldv_stages = {2'h2, 4'h8, 5'h02};
			5'h0A: ldv_stages = {2'h3, 4'h6, 5'h02};
			5'h0B: ldv_stages = {2'h3, 4'h8, 5'h02};
			5'h0C: ldv_stages = {2'h2, 4'h8, 5'h04};
			5'h0D: ldv_stages = {2'h2, 4'h8, 5'h06};
			5'h0E: ldv_stages = {2'h2, 4'h8, 5'h08};
			5'h0F: ldv_stages = {2'h3, 4'h8, 5'h08};
			5'h10: ldv_stages = {2'h2, 4'h8, 5'h10};
			5'h11: ldv_stages = {2'h3, 4'h8, 5'h10};
			default: ldv_stages = 11'h000;
		endcase
	endfunction
endpackage

/* design/ldv_tick_gen.sv */
// state machine clock enable: one-cycle pulse every 1, 2, 4 or 8 cycles.
// assumes clk_sys is the reference clock itself.
`timescale 1ns/1ps
module ldv_tick_gen (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [1:0] div_sel,
	output logic tick
);
	logic [2:0] cnt_q;
	logic [2:0] last;

	// terminal count is 2^div_sel - 1
	assign last = 3'((4'h1 << div_sel) - 4'h1);

	// reference divided by power of two
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_q <= 3'h0;
			tick <= 1'b0;
		end else if (cnt_q >= last) begin
			cnt_q <= 3'h0;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 3'h1;
			tick <= 1'b0;
		end
	end
endmodule

/* design/ldv_top.sv */
// lock-detect generator, vco calibration sequencer, channel divider
// decode and power, and their axi4-lite register file.
// assumes analog comparators and the tuning-voltage detector arrive
// asynchronously and are synchronised here.
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module ldv_top (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [ldv_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ldv_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic vtune_lock_in,
	input wire logic vco_freq_low_in,
	input wire logic vco_freq_high_in,
	output logic multiplexed_status_pin,
	output logic outputs_enable,
	output logic output_divide_code_powered,
	output logic [1:0] divider_stage_b,
	output logic [3:0] divider_stage_c,
	output logic [4:0] divider_stage_d,
	output logic [2:0] vco_core,
	output logic [8:0] amplitude_value,
	output logic [7:0] band_value
);
	import ldv_pkg::*;

	logic [31:0] ctrl0_q;
	logic [15:0] lock_detect_delay;
	logic [31:0] vco_start_q;
	logic [31:0] vco_force_q;
	logic [31:0] output_divide_code_q;
	logic [5:0] rb_sel_q;
	logic aw_have_q, w_have_q;
	logic [AXI_AW-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic wr_fire;
	logic [2:0] sync1_q, sync2_q;
	logic vtune_lock_s, freq_low_s, freq_high_s;
	logic sm_tick;
	ldv_cal_state_t cal_state_q;
	logic [7:0] amp_cnt_q;
	logic [15:0] dly_cnt_q;
	logic cal_start;
	logic all_forced;
	logic ld_now, ld_q;
	logic [1:0] lock_state_readback;
	logic [31:0] rb_shift_q;
	logic [10:0] stages;
	logic [9:0] div_ratio_q;
	logic div_invalid;
	logic [1:0] out_a_sel, out_b_sel;

	// merge a write through its byte enables
	function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			strobe_merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
		end
	endfunction

	// readable word at an address; the same view feeds the pin readback
	function automatic logic [31:0] reg_view(input logic [AXI_AW-1:0] addr);
		case (addr)
			ADDR_CTRL0: reg_view = ctrl0_q;
			ADDR_LD_DELAY: reg_view = {16'h0000, lock_detect_delay};
			ADDR_VCO_START: reg_view = vco_start_q;
			ADDR_VCO_FORCE: reg_view = vco_force_q;
			ADDR_OUTPUT_DIVIDE_CODE: reg_view = output_divide_code_q;
			// lock status and cal results visible
			ADDR_STATUS: reg_view = {24'h0000_00, 1'b0, div_invalid, output_divide_code_powered,
				outputs_enable, ld_q, (cal_state_q != CAL_IDLE), lock_state_readback};
			ADDR_CAL_RESULT: reg_view = {8'h00, band_value, 3'h0, amplitude_value,
				1'b0, vco_core};
			ADDR_DIV_INFO: reg_view = {10'h000, div_ratio_q, 1'b0, stages};
			ADDR_RB_SEL: reg_view = {26'h000_0000, rb_sel_q};
			default: reg_view = 32'h0000_0000;
		endcase
	endfunction

	function automatic logic addr_mapped(input logic [AXI_AW-1:0] addr);
		addr_mapped = (addr <= ADDR_RB_SEL) && (addr[1:0] == 2'h0);
	endfunction

	// asynchronous analog levels: two flops before use
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
				end else begin
					sync1_q[gi] <= (gi == 0) ? vtune_lock_in :
						(gi == 1) ? vco_freq_low_in : vco_freq_high_in;
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate
	assign vtune_lock_s = sync2_q[0];
	assign freq_low_s = sync2_q[1];
	assign freq_high_s = sync2_q[2];

	ldv_tick_gen u_tick (
		.clk_sys(clk_sys),
		.rst(rst),
		.div_sel(ctrl0_q[CTRL_CALDIV_LSB +: 2]),
		.tick(sm_tick)
	);

	// axi write channels, taken in either order, answered once both held
	assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addr_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// axi read: one-cycle accept, data registered the cycle after
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= reg_view(s_axi_araddr);
				s_axi_rresp <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// writable registers; status words ignore writes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl0_q <= CTRL0_RST;
			lock_detect_delay <= LD_DELAY_RST;
			vco_start_q <= VCO_START_RST;
			vco_force_q <= VCO_FORCE_RST;
			output_divide_code_q <= OUTPUT_DIVIDE_CODE_RST;
			rb_sel_q <= 6'h00;
		end else if (wr_fire) begin
			case (aw_addr_q)
				ADDR_CTRL0: ctrl0_q <= strobe_merge(ctrl0_q, w_data_q, w_strb_q);
				ADDR_LD_DELAY: lock_detect_delay <= 16'(strobe_merge({16'h0000,
					lock_detect_delay}, w_data_q, w_strb_q));
				ADDR_VCO_START: vco_start_q <= strobe_merge(vco_start_q, w_data_q, w_strb_q);
				ADDR_VCO_FORCE: vco_force_q <= strobe_merge(vco_force_q, w_data_q, w_strb_q);
				ADDR_OUTPUT_DIVIDE_CODE: output_divide_code_q <= strobe_merge(output_divide_code_q, w_data_q, w_strb_q);
				ADDR_RB_SEL: rb_sel_q <= w_strb_q[0] ? w_data_q[5:0] : rb_sel_q;
				default: ;
			endcase
		end
	end

	// a control write with byte 0 enabled starts a calibration
	assign cal_start = wr_fire && (aw_addr_q == ADDR_CTRL0) && w_strb_q[0];
	assign all_forced = vco_start_q[FORCE_CORE_BIT] && vco_start_q[FORCE_AMP_BIT] &&
		vco_start_q[FORCE_BAND_BIT];

	// calibration sequencer; a fresh write restarts it even mid-run
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cal_state_q <= CAL_IDLE;
			amp_cnt_q <= 8'h00;
			dly_cnt_q <= 16'h0000;
			vco_core <= VCO_START_RST[CORE_LSB +: 3];
			amplitude_value <= VCO_START_RST[AMP_LSB +: 9];
			band_value <= VCO_START_RST[BAND_LSB +: 8];
		end else if (cal_start) begin
			amp_cnt_q <= 8'h00;
			dly_cnt_q <= 16'h0000;
			if (all_forced) begin
				vco_core <= vco_force_q[CORE_LSB +: 3];
				amplitude_value <= vco_force_q[AMP_LSB +: 9];
				band_value <= vco_force_q[BAND_LSB +: 8];
				cal_state_q <= CAL_DELAY;
			end else begin
				vco_core <= vco_start_q[CORE_LSB +: 3];
				// reuse keeps held band and amplitude
				if (!w_data_q[CTRL_REUSE_BIT]) begin
					amplitude_value <= vco_start_q[AMP_LSB +: 9];
					band_value <= vco_start_q[BAND_LSB +: 8];
				end
				// band search only with trigger set
				cal_state_q <= CAL_AMP;
				if (!w_data_q[CTRL_FCAL_BIT]) begin
					amp_cnt_q <= 8'h00;
				end
			end
		end else begin
			case (cal_state_q)
				CAL_AMP: begin
					if (sm_tick) begin
						amp_cnt_q <= amp_cnt_q + 8'h01;
						if (amp_cnt_q == AMP_CAL_TICKS - 8'h01) begin
							cal_state_q <= ctrl0_q[CTRL_FCAL_BIT] ? CAL_FREQ : CAL_DELAY;
						end
					end
				end
				CAL_FREQ: begin
					// search from any start to the end
					if (sm_tick) begin
						if (freq_low_s && band_value != 8'h00) begin
							band_value <= band_value - 8'h01;
						end else if (freq_high_s && band_value != BAND_TOP) begin
							band_value <= band_value + 8'h01;
						end else begin
							cal_state_q <= CAL_DELAY;
						end
					end
				end
				CAL_DELAY: begin
					if (dly_cnt_q == lock_detect_delay) begin
						cal_state_q <= CAL_IDLE;
					end else if (sm_tick) begin
						dly_cnt_q <= dly_cnt_q + 16'h0001;
					end
				end
				default: cal_state_q <= CAL_IDLE;
			endcase
		end
	end

	assign ld_now = (ctrl0_q[CTRL_LDTYPE_BIT] == LOCK_DETECT_TYPE_VTUNE) ? vtune_lock_s :
		(cal_state_q == CAL_IDLE);

	// lock, mute and pin, all registered
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ld_q <= 1'b0;
			lock_state_readback <= LOCK_STATE_UNLOCKED;
			outputs_enable <= 1'b0;
			multiplexed_status_pin <= 1'b0;
		end else begin
			ld_q <= ld_now;
			// tuning lock reads back state 2
			lock_state_readback <= vtune_lock_s ? LOCK_STATE_LOCKED : LOCK_STATE_UNLOCKED;
			outputs_enable <= !(ctrl0_q[CTRL_MUTE_BIT] && !ld_now);
			multiplexed_status_pin <= (ctrl0_q[CTRL_MUXSEL_BIT] == MUX_SEL_LOCK) ? ld_now :
				rb_shift_q[31];
		end
	end

	// pin readback shifts the chosen word msb first per state tick
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rb_shift_q <= 32'h0000_0000;
		end else if (wr_fire && aw_addr_q == ADDR_RB_SEL && w_strb_q[0]) begin
			rb_shift_q <= reg_view({w_data_q[5:0], 2'h0});
		end else if (sm_tick) begin
			rb_shift_q <= {rb_shift_q[30:0], 1'b0};
		end
	end

	assign stages = ldv_stages(output_divide_code_q[DIV_CODE_LSB +: 5]);
	assign div_invalid = output_divide_code_q[DIV_CODE_LSB +: 5] > DIV_CODE_MAX;
	assign out_a_sel = output_divide_code_q[OUTA_SEL_LSB +: 2];
	assign out_b_sel = output_divide_code_q[OUTB_SEL_LSB +: 2];

	// divider decode and power, registered toward the analog stages
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			divider_stage_b <= 2'h0;
			divider_stage_c <= 4'h0;
			divider_stage_d <= 5'h00;
			div_ratio_q <= 10'h000;
			output_divide_code_powered <= 1'b0;
		end else begin
			divider_stage_b <= stages[10:9];
			divider_stage_c <= stages[8:5];
			divider_stage_d <= stages[4:0];
			// total is product of four stages
			// widen each factor first so the product keeps its upper bits
			div_ratio_q <= 10'(STAGE_A_RATIO) * 10'(stages[10:9]) * 10'(stages[8:5]) *
				10'(stages[4:0]);
			output_divide_code_powered <= !output_divide_code_q[DIV_PD_BIT] || out_a_sel == SRC_OUTPUT_DIVIDE_CODE ||
				out_b_sel == SRC_OUTPUT_DIVIDE_CODE || out_b_sel == SRC_SYSREF;
		end
	end

	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	pin_select_a: assert property (
		ctrl0_q[CTRL_MUXSEL_BIT] == MUX_SEL_READBACK |=> multiplexed_status_pin == $past(rb_shift_q[31]))
		else $error("status pin not carrying readback");
	cal_low_a: assert property (
		ctrl0_q[CTRL_LDTYPE_BIT] == LOCK_DETECT_TYPE_CAL && cal_state_q != CAL_IDLE |=> !ld_q)
		else $error("lock high during calibration");
	vtune_lock_a: assert property (
		ctrl0_q[CTRL_LDTYPE_BIT] == LOCK_DETECT_TYPE_VTUNE && vtune_lock_s |=>
		ld_q && lock_state_readback == LOCK_STATE_LOCKED)
		else $error("tuning lock not reported");
	mute_out_a: assert property (
		ctrl0_q[CTRL_MUTE_BIT] && !ld_q ##1 ctrl0_q[CTRL_MUTE_BIT] && !ld_q |-> !outputs_enable)
		else $error("outputs on while lock low");
	cal_start_a: assert property (
		cal_start && !all_forced |=> cal_state_q == CAL_AMP && amp_cnt_q == 8'h00)
		else $error("control write did not start amplitude cal");
	delay_clear_a: assert property (
		cal_start |=> dly_cnt_q == 16'h0000)
		else $error("delay count not cleared on start");
	force_apply_a: assert property (
		cal_start && all_forced |=> band_value == $past(vco_force_q[BAND_LSB +: 8]) &&
		cal_state_q == CAL_DELAY)
		else $error("forced band not applied");
	reuse_hold_a: assert property (
		cal_start && !all_forced && w_data_q[CTRL_REUSE_BIT] |=> $stable(band_value))
		else $error("reuse did not keep band");
	delay_len_a: assert property (
		cal_state_q == CAL_DELAY && dly_cnt_q != lock_detect_delay && !cal_start |=>
		cal_state_q == CAL_DELAY)
		else $error("delay ended early");
	ratio_top_a: assert property (
		output_divide_code_q[DIV_CODE_LSB +: 5] == DIV_CODE_MAX |=> div_ratio_q == 10'h300)
		else $error("top divide code ratio wrong");
	div_power_a: assert property (
		out_a_sel == SRC_OUTPUT_DIVIDE_CODE |=> output_divide_code_powered)
		else $error("divider unpowered while selected");

	cal_full_c: cover property (cal_state_q == CAL_FREQ ##[1:300] cal_state_q == CAL_IDLE);
	forced_c: cover property (cal_start && all_forced);
	readback_c: cover property (ctrl0_q[CTRL_MUXSEL_BIT] == MUX_SEL_READBACK && multiplexed_status_pin);
endmodule

/* verif/ldv_vco_model.sv */
// vco band comparator model standing beside the calibration sequencer.
// assumes band_value comes from ldv_top and target is set by the bench.
`timescale 1ns/1ps
module ldv_vco_model (
	input wire logic [7:0] band_value,
	input wire logic [7:0] target,
	output logic vco_freq_low_in,
	output logic vco_freq_high_in
);
	// higher band code gives a lower frequency; both low once on target
	always_comb begin
		vco_freq_low_in = band_value > target;
		vco_freq_high_in = band_value < target;
	end
endmodule

/* verif/ldv_top_test.sv */
// self-checking bench for ldv_top: axi4-lite host tasks and vco model.
// assumes one 10 MHz clock that is also the calibration reference.
`timescale 1ns/1ps
module ldv_top_test;
	import ldv_pkg::*;
	logic clk_sys, rst, awvalid, wvalid, bready, arvalid, rready, vtune;
	logic awready, wready, bvalid, arready, rvalid, lo, hi, pin, oen, pwr;
	logic [7:0] awaddr, araddr, target, band;
	logic [31:0] wdata, rdata, rd, v;
	logic [47:0] sh;
	logic [3:0] wstrb, sc;
	logic [1:0] bresp, rresp, rsp, sb;
	logic [4:0] sd;
	logic [2:0] core;
	logic [8:0] amp;
	int failures, checks_done, cyc, n, t0;
	logic [31:0] seed;
	int rb[18] = '{1, 2, 3, 2, 3, 2, 2, 2, 3, 2, 3, 3, 2, 2, 2, 3, 2, 3};
	int rc[18] = '{1, 1, 1, 2, 2, 4, 6, 8, 8, 8, 6, 8, 8, 8, 8, 8, 8, 8};
	int rdv[18] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 2, 2, 2, 4, 6, 8, 8, 16, 16};
	int rt[18] = '{2, 4, 6, 8, 12, 16, 24, 32, 48, 64, 72, 96, 128, 192, 256, 384, 512, 768};

	ldv_top u_ldv_top (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .vtune_lock_in(vtune), .vco_freq_low_in(lo),
		.vco_freq_high_in(hi), .multiplexed_status_pin(pin), .outputs_enable(oen),
		.output_divide_code_powered(pwr), .divider_stage_b(sb), .divider_stage_c(sc),
		.divider_stage_d(sd), .vco_core(core), .amplitude_value(amp), .band_value(band));
	ldv_vco_model u_ldv_vco_model (.band_value(band), .target(target),
		.vco_freq_low_in(lo), .vco_freq_high_in(hi));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// watchdog cuts a hang short
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 95000) begin
			failures++;
			results();
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// axi4-lite write: both channels offered together, held until taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		rsp = bresp;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		rd = rdata;
		rsp = rresp;
	endtask

	// control write, then count cycles of low lock indication
	task automatic cal(input logic [31:0] c);
		wr(ADDR_CTRL0, c);
		@(posedge clk_sys);
		#1;
		n = 0;
		while (pin !== 1'b1 && n < 70000) begin
			@(posedge clk_sys);
			#1;
			n++;
			if (c[CTRL_MUTE_BIT]) chk({31'h0, oen}, {31'h0, pin});
		end
	endtask

	// low interval must cover amplitude cal, band steps and the delay
	task automatic run(input logic [31:0] c, input int steps, input int d);
		int p;
		p = 1 << c[6:5];
		wr(ADDR_LD_DELAY, d);
		cal(c);
		chk(n >= p * (15 + steps + d) && n <= p * (18 + steps + d) + 6, 1);
	endtask

	task automatic results();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, vtune} = 6'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hf;
		target = 8'hb7;
		seed = 84184;
		rst = 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		rd_reg(ADDR_VCO_START);
		chk(rd, {8'h00, 8'hb7, 3'h0, 9'h12c, 1'h0, 3'h7});
		rd_reg(8'h40);
		chk({rd[29:0], rsp}, {30'h0, RESP_SLVERR});
		wr(8'h40, 32'h0000_0001);
		chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
		// every divide code, random sources and power-down
		for (int i = 0; i < 32; i++) begin
			v = rnd();
			// an unused source maps to the vco path
			if (v[10:9] == 2'h3) v[10:9] = 2'h1;
			if (v[12:11] == 2'h3) v[12:11] = 2'h1;
			wr(ADDR_OUTPUT_DIVIDE_CODE, {19'h0, v[12:8], 3'h0, i[4:0]});
			#1;
			chk(pwr, !v[8] || v[10:9] == 2'h0 || v[12:11] == 2'h0 || v[12:11] == 2'h2);
			if (i < 18) begin
				chk({21'h0, sb, sc, sd}, (rb[i] << 9) | (rc[i] << 5) | rdv[i]);
				chk(2 * sb * sc * sd, rt[i]);
			end else begin
				chk({21'h0, sb, sc, sd}, 32'h0);
			end
		end
		// core 1 start interpolated for 8050 MHz, then band search
		wr(ADDR_VCO_START, {8'h00, 8'h58, 3'h0, 9'h10e, 1'h0, 3'h1});
		target <= 8'd60 + 8'(rnd() % 60);
		t0 = 88;
		#1;
		run(32'h0000_0075, (target > t0) ? target - t0 : t0 - target, rnd() % 64);
		chk(band, target);
		// reuse starts from the held band, not the programmed start
		t0 = target;
		target <= 8'd60 + 8'(rnd() % 60);
		#1;
		run(32'h0000_0077, (target > t0) ? target - t0 : t0 - target, 3);
		chk(band, target);
		// write without trigger still runs amplitude cal; longest delay
		run(32'h0000_0014, 0, 65535);
		// fixed start inside the special band
		wr(ADDR_VCO_START, {8'h00, 8'h01, 3'h0, 9'h12c, 1'h0, 3'h4});
		target <= 8'h01;
		run(32'h0000_0075, 0, 0);
		chk({core, band}, {3'h4, 8'h01});
		// all three force bits apply the programmed values
		wr(ADDR_VCO_FORCE, {8'h00, 8'h42, 3'h0, 9'h0aa, 1'h0, 3'h5});
		wr(ADDR_VCO_START, {5'h00, 3'h7, 8'h01, 3'h0, 9'h12c, 1'h0, 3'h4});
		cal(32'h0000_0075);
		chk({core, amp, band}, {3'h5, 9'h0aa, 8'h42});
		wr(ADDR_VCO_START, {8'h00, 8'h01, 3'h0, 9'h12c, 1'h0, 3'h4});
		// tuning-voltage lock type follows the detector
		wr(ADDR_CTRL0, 32'h0000_000c);
		for (int k = 0; k < 2; k++) begin
			vtune <= !k[0];
			repeat (6) @(posedge clk_sys);
			#1;
			chk(pin, !k[0]);
			rd_reg(ADDR_STATUS);
			chk(rd[1:0], k[0] ? LOCK_STATE_UNLOCKED : LOCK_STATE_LOCKED);
		end
		// readback of the start word shifted out msb first
		wr(ADDR_CTRL0, 32'h0000_0000);
		wr(ADDR_RB_SEL, 32'h0000_0002);
		n = 0;
		for (int j = 0; j < 48; j++) begin
			#1;
			sh = {sh[46:0], pin};
			@(posedge clk_sys);
		end
		for (int j = 0; j <= 16; j++) begin
			if (sh[j+:32] === 32'h0001_12c4) n = 1;
		end
		chk(n, 1);
		results();
	end
endmodule
